// ===== hw/isoch_defines.vh
// Constants for the isochronous IN endpoint stream logic
`ifndef ISOCH_DEFINES_VH
`define ISOCH_DEFINES_VH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define ISO_TIME_W        32
`define ISO_DATA_W        32
`define ISO_SEQ_W         5
`define ISO_FIFO_DEPTH    16
`define ISO_FIFO_ADDR_W   4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ISO_SEQ_RESET     5'h00
`define ISO_TIME_RESET    32'h00000000
`define ISO_DATA_RESET    32'h00000000

// ----------------------------------------------------------------
// Answer states
// ----------------------------------------------------------------
`define ISO_ST_HOLD       1'b0
`define ISO_ST_RUN        1'b1

`endif

// ===== hw/pkt_fifo.v
// Packet FIFO with drop-oldest support, flip-flop storage
module pkt_fifo #(
	parameter WIDTH  = 64,
	parameter DEPTH  = 16,
	parameter ADDR_W = 4
)(
	input  wire              clk_in,
	input  wire              rst_n_in,
	input  wire              in_valid_in,
	output wire              in_ready_out,
	input  wire [WIDTH-1:0]  in_data_in,
	input  wire              drop_in,
	output wire              out_valid_out,
	input  wire              out_ready_in,
	output wire [WIDTH-1:0]  out_data_out
);
	reg  [WIDTH-1:0]  mem_reg [0:DEPTH-1];
	reg  [ADDR_W-1:0] wr_ptr_reg;
	reg  [ADDR_W-1:0] rd_ptr_reg;
	reg  [ADDR_W:0]   count_reg;
	wire              full;
	wire              empty;
	wire              push;
	wire              pop;

	assign full          = (count_reg == DEPTH[ADDR_W:0]);
	assign empty         = (count_reg == {(ADDR_W+1){1'b0}});
	assign in_ready_out  = ~full;
	assign out_valid_out = ~empty;
	assign out_data_out  = mem_reg[rd_ptr_reg];
	// A drop frees the head slot in the same cycle, so a push may follow it
	assign pop  = ~empty & (out_ready_in | drop_in);
	assign push = in_valid_in & (~full | pop);

	// ----------------------------------------------------------------
	// Pointers and storage
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wr_ptr_reg <= {ADDR_W{1'b0}};
			rd_ptr_reg <= {ADDR_W{1'b0}};
			count_reg  <= {(ADDR_W+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	always @(posedge clk_in)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data_in;
	end
endmodule

// ===== hw/isoch_in_endpoint.v
// Isochronous IN endpoint: start-time hold-off, time stamping and overflow discard
//
// Function
// - Before a configured start time, every data request is answered with a NAK.
// - From the start time on, data is produced and requests are answered normally.
// - Each packet carries a header with a presentation time ahead of its data segments.
// - The header presentation time belongs to the first segment only.
// - Later segment times follow from the endpoint service interval.
// - Each IN packet is stamped with the channel time at which its data was produced, or one past the previous stamp if that time is not later.
// - A discarded packet's presentation time is never given to another packet.
// - A packet produced into a full buffer pushes out the oldest buffered packet.
// - After a discard, the next packet goes out with the discarded packet's sequence number.
// - One start-time request may align several streams to a common start.
`include "isoch_defines.vh"

module isoch_in_endpoint #(
	parameter TIME_W  = `ISO_TIME_W,
	parameter DATA_W  = `ISO_DATA_W,
	parameter SEQ_W   = `ISO_SEQ_W,
	parameter DEPTH   = `ISO_FIFO_DEPTH,
	parameter ADDR_W  = `ISO_FIFO_ADDR_W
)(
	input  wire              clk_in,
	input  wire              rst_n_in,
	input  wire [TIME_W-1:0] channel_time_in,
	input  wire              start_time_en_in,
	input  wire [TIME_W-1:0] start_time_in,
	input  wire [TIME_W-1:0] endpoint_service_interval_in,
	input  wire              prod_valid_in,
	input  wire [DATA_W-1:0] prod_data_in,
	input  wire              req_in,
	input  wire              ack_in,
	output reg               prod_taken_out,
	output reg               prod_drop_out,
	output reg               running_out,
	output reg               resp_valid_out,
	output reg               resp_nak_out,
	output reg  [SEQ_W-1:0]  resp_seq_out,
	output reg  [TIME_W-1:0] resp_pres_time_out,
	output reg  [TIME_W-1:0] resp_seg2_time_out,
	output reg  [DATA_W-1:0] resp_data_out,
	output reg  [SEQ_W-1:0]  drop_count_out
);
	localparam PKT_W = TIME_W + DATA_W;
	localparam ST_HOLD = `ISO_ST_HOLD;
	localparam ST_RUN  = `ISO_ST_RUN;

	reg               state_reg;
	reg               state_next;
	reg  [TIME_W-1:0] last_stamp_reg;
	reg               stamp_used_reg;
	reg  [SEQ_W-1:0]  seq_reg;
	reg               outstanding_reg;
	reg  [TIME_W-1:0] stamp;
	wire              fifo_in_ready;
	wire              fifo_out_valid;
	wire [PKT_W-1:0]  fifo_out_data;
	wire              produce;
	wire              drop;
	wire [TIME_W-1:0] head_time;
	wire [DATA_W-1:0] head_data;
	wire              head_acked;

	// ----------------------------------------------------------------
	// Start-time hold-off
	// ----------------------------------------------------------------
	// Signed distance keeps the compare correct across a channel-time wrap
	function time_before;
		input [TIME_W-1:0] a;
		input [TIME_W-1:0] b;
		reg   [TIME_W-1:0] d;
		begin
			d = a - b;
			time_before = d[TIME_W-1];
		end
	endfunction

	// The start inputs may be shared by several endpoints to align their streams
	// Once running, the endpoint stays running until the next reset
	// shared start alignment
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_HOLD:
			begin
				if (!start_time_en_in || !time_before(channel_time_in, start_time_in))
					state_next = ST_RUN;
			end
			ST_RUN:
				state_next = ST_RUN;
			default:
				state_next = ST_HOLD;
		endcase
	end

	// ----------------------------------------------------------------
	// Production and stamping
	// ----------------------------------------------------------------
	// stamp production time
	always @*
	begin
		stamp = channel_time_in;
		if (stamp_used_reg && !time_before(last_stamp_reg, channel_time_in))
			stamp = last_stamp_reg + {{(TIME_W-1){1'b0}}, 1'b1};
	end

	assign produce = prod_valid_in & (state_reg == ST_RUN);
	assign drop    = produce & ~fifo_in_ready;

	assign head_time  = fifo_out_data[PKT_W-1:DATA_W];
	assign head_data  = fifo_out_data[DATA_W-1:0];
	assign head_acked = ack_in & outstanding_reg & fifo_out_valid;

	pkt_fifo #(
		.WIDTH  (PKT_W),
		.DEPTH  (DEPTH),
		.ADDR_W (ADDR_W)
	) u_fifo (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (produce),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    ({stamp, prod_data_in}),
		.drop_in       (drop),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (head_acked & ~drop),
		.out_data_out  (fifo_out_data)
	);

	// ----------------------------------------------------------------
	// State, stamps and burst sequence
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg       <= ST_HOLD;
			last_stamp_reg  <= `ISO_TIME_RESET;
			stamp_used_reg  <= 1'b0;
			seq_reg         <= `ISO_SEQ_RESET;
			outstanding_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			if (produce)
			begin
				last_stamp_reg <= stamp;
				stamp_used_reg <= 1'b1;
			end
			if (head_acked && !drop)
				seq_reg <= seq_reg + 1'b1;
			// A drop retires the attempt even when a request lands with it,
			// since that answer carried the packet now gone; an ack retires it too
			if (drop)
				outstanding_reg <= 1'b0;
			else if (req_in && state_reg == ST_RUN && fifo_out_valid)
				outstanding_reg <= 1'b1;
			else if (head_acked)
				outstanding_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Answers to data requests
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			prod_taken_out     <= 1'b0;
			prod_drop_out      <= 1'b0;
			running_out        <= 1'b0;
			resp_valid_out     <= 1'b0;
			resp_nak_out       <= 1'b0;
			resp_seq_out       <= `ISO_SEQ_RESET;
			resp_pres_time_out <= `ISO_TIME_RESET;
			resp_seg2_time_out <= `ISO_TIME_RESET;
			resp_data_out      <= `ISO_DATA_RESET;
			drop_count_out     <= `ISO_SEQ_RESET;
		end
		else
		begin
			prod_taken_out <= produce;
			prod_drop_out  <= drop;
			running_out    <= (state_reg == ST_RUN);
			resp_valid_out <= req_in;
			if (drop)
				drop_count_out <= drop_count_out + 1'b1;
			if (req_in)
			begin
				if (state_reg != ST_RUN || !fifo_out_valid)
					resp_nak_out <= 1'b1;
				else
				begin
					resp_nak_out <= 1'b0;
					resp_pres_time_out <= head_time;
					resp_data_out      <= head_data;
					resp_seg2_time_out <= head_time + endpoint_service_interval_in;
					resp_seq_out       <= seq_reg;
				end
			end
		end
	end
endmodule

// ===== bench/endpoint_checker_assertions.sv
// Port checker for the isochronous IN endpoint
module endpoint_checker #(
	parameter TIME_W = 32,
	parameter SEQ_W  = 5
)(
	input wire logic              clk_in,
	input wire logic              rst_n_in,
	input wire logic              req_in,
	input wire logic              prod_valid_in,
	input wire logic [TIME_W-1:0] endpoint_service_interval_in,
	input wire logic              running_out,
	input wire logic              prod_taken_out,
	input wire logic              prod_drop_out,
	input wire logic              resp_valid_out,
	input wire logic              resp_nak_out,
	input wire logic [TIME_W-1:0] resp_pres_time_out,
	input wire logic [TIME_W-1:0] resp_seg2_time_out,
	input wire logic [SEQ_W-1:0]  drop_count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	answer_follows_a: assert property (req_in |=> resp_valid_out)
		else $error("no answer");
	spurious_answer_a: assert property (!req_in |=> !resp_valid_out)
		else $error("extra answer");
	hold_nak_a: assert property (req_in && !running_out |=> resp_nak_out)
		else $error("no nak");
	// running_out and prod_taken_out lag the state by the same one cycle
	hold_ignore_a: assert property (!running_out |-> !prod_taken_out)
		else $error("data taken early");
	run_take_a: assert property (prod_valid_in && running_out |=> prod_taken_out)
		else $error("data not taken");
	segment_time_a: assert property (resp_valid_out && !resp_nak_out
		|-> resp_seg2_time_out == resp_pres_time_out + endpoint_service_interval_in)
		else $error("segment time wrong");
	drop_push_a: assert property (prod_drop_out |-> prod_taken_out)
		else $error("drop alone");
	drop_count_a: assert property (prod_drop_out
		|-> drop_count_out == $past(drop_count_out) + 1'b1)
		else $error("drop count wrong");
	cover property (resp_valid_out && resp_nak_out);
	cover property (resp_valid_out && !resp_nak_out);
	cover property (prod_drop_out);
endmodule

bind isoch_in_endpoint endpoint_checker #(.TIME_W(TIME_W), .SEQ_W(SEQ_W)) endpoint_checker_i (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.req_in(req_in),
	.prod_valid_in(prod_valid_in),
	.endpoint_service_interval_in(endpoint_service_interval_in),
	.running_out(running_out),
	.prod_taken_out(prod_taken_out),
	.prod_drop_out(prod_drop_out),
	.resp_valid_out(resp_valid_out),
	.resp_nak_out(resp_nak_out),
	.resp_pres_time_out(resp_pres_time_out),
	.resp_seg2_time_out(resp_seg2_time_out),
	.drop_count_out(drop_count_out)
);

// ===== bench/host_model.sv
// Host side model: issues data requests and acknowledges good answers
module host_model (
	input  wire logic clk_in,
	input  wire logic req_cmd_in,
	input  wire logic ack_en_in,
	input  wire logic resp_valid_in,
	input  wire logic resp_nak_in,
	output logic      req_out = 1'b0,
	output logic      ack_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// This model only runs IN transfers, so the OUT-stream duties never arise here
	// no OUT stamping
	always @(posedge clk_in)
	begin
		req_out <= req_cmd_in;
		ack_out <= ack_en_in & resp_valid_in & ~resp_nak_in;
	end
endmodule

// ===== bench/isoch_in_endpoint_test.sv
// Self-checking bench for the isochronous IN endpoint
module isoch_in_endpoint_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk_in = 1'b0;
	logic         rst_n_in = 1'b0;
	logic [31:0]  channel_time_in = 32'h0;
	logic [31:0]  start_time_in = 32'h64;
	logic [31:0]  ivl = 32'h0;
	logic         prod_valid_in = 1'b0;
	logic [31:0]  prod_data_in = 32'h0;
	logic         req_cmd = 1'b0;
	logic         ack_en = 1'b0;
	logic         start_en = 1'b1;
	logic         req_in, ack_in, taken, dropped, running, rv, nak;
	logic [4:0]   rseq, dcnt, seq = 5'h0;
	logic [31:0]  rtime, rseg, rdata;
	logic [31:0]  md[$], mt[$];
	logic [101:0] expq[$];
	int           err_total = 0, n_checks = 0, seed = 70164;
	bit           run = 1'b0;

	always #2.5 clk_in = ~clk_in;

	host_model host_model_i (.clk_in(clk_in), .req_cmd_in(req_cmd), .ack_en_in(ack_en),
		.resp_valid_in(rv), .resp_nak_in(nak), .req_out(req_in), .ack_out(ack_in));

	isoch_in_endpoint isoch_in_endpoint_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.channel_time_in(channel_time_in), .start_time_en_in(start_en),
		.start_time_in(start_time_in), .endpoint_service_interval_in(ivl),
		.prod_valid_in(prod_valid_in), .prod_data_in(prod_data_in), .req_in(req_in),
		.ack_in(ack_in), .prod_taken_out(taken), .prod_drop_out(dropped),
		.running_out(running), .resp_valid_out(rv), .resp_nak_out(nak),
		.resp_seq_out(rseq), .resp_pres_time_out(rtime), .resp_seg2_time_out(rseg),
		.resp_data_out(rdata), .drop_count_out(dcnt));

	task complete_run;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk_resp(input logic [101:0] e, input logic [101:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR answer expected %h seen %h", e, g);
		end
	endtask

	task chk_cnt(input logic [4:0] e, input logic [4:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR drop_count expected %h seen %h", e, g);
		end
	endtask

	// Stamp follows the channel time driven with the data
	task prod;
		logic [31:0] d, t;
		d = $random(seed);
		t = channel_time_in + 32'h1 + ($random(seed) & 32'h3);
		if (run)
		begin
			md.push_back(d);
			mt.push_back(t);
			if (md.size() > 16)
			begin
				md.pop_front();
				mt.pop_front();
			end
		end
		@(posedge clk_in);
		prod_valid_in <= 1'b1;
		prod_data_in <= d;
		channel_time_in <= t;
		@(posedge clk_in);
		prod_valid_in <= 1'b0;
	endtask

	task req(input bit a);
		logic [101:0] e;
		if (!run || md.size() == 0)
			e = {1'b1, 101'h0};
		else
			e = {1'b0, seq, mt[0], mt[0] + ivl, md[0]};
		expq.push_back(e);
		@(posedge clk_in);
		req_cmd <= 1'b1;
		ack_en <= a;
		@(posedge clk_in);
		req_cmd <= 1'b0;
		repeat (4) @(posedge clk_in);
		ack_en <= 1'b0;
		if (a && !e[101])
		begin
			md.pop_front();
			mt.pop_front();
			seq++;
		end
	endtask

	always @(negedge clk_in)
		if (rv === 1'b1)
			chk_resp(expq.pop_front(), (nak === 1'b1) ? {1'b1, 101'h0} :
				{nak, rseq, rtime, rseg, rdata});

	initial
	begin
		#50000;
		err_total++;
		$display("ERROR watchdog expected finish seen timeout");
		complete_run;
	end

	initial
	begin
		@(posedge clk_in);
		ivl <= 32'h1 + ($random(seed) & 32'hf);
		repeat (7) @(posedge clk_in);
		rst_n_in <= 1'b1;
		req(1'b0);
		prod;
		req(1'b1);
		@(posedge clk_in);
		channel_time_in <= start_time_in;
		repeat (3) @(posedge clk_in);
		run = 1'b1;
		req(1'b0);
		repeat (16) prod;
		req(1'b0);
		req(1'b0);
		prod;
		req(1'b1);
		repeat (16) req(1'b1);
		chk_cnt(5'h01, dcnt);
		// Mid-run reset with no start time configured: the endpoint runs at once
		rst_n_in <= 1'b0;
		start_en <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk_cnt(5'h00, dcnt);
		rst_n_in <= 1'b1;
		md.delete();
		mt.delete();
		seq = 5'h0;
		prod;
		req(1'b1);
		repeat (4) @(posedge clk_in);
		complete_run;
	end
endmodule
